// File: hdl/pio_channel_register_decode.sv
// Register decode of a programmed_io interface with its channels
//
// Behaviour
// - The interface answers only addresses from its base number up to base plus block size minus one.
// - Each channel has a command, a condition and a data register at its own number.
// - A command register only takes writes, and the written word acts as a command.
// - A condition register is only read and shows ready, active and error state.
// - Output data takes writes only and input data is read only.
// - The two-channel form runs input and output at once; one-channel is one direction.
// - Each channel has its own registers and is steered independently of the other.
// - Printer form: command at 3, condition at 2, data at 1, loop-back of data at 0.
// - Terminal input: command at 3, condition at 2, received data at 0.
// - Terminal output: command at 7, condition at 6, transmit data at 5.
// - Terminal form has one shared line speed register at 1.
// - Address bit 0 gives direction: even reads, odd writes.
// - The block is a run of 4 to 16 consecutive addresses from the base number.
// - The base number comes from a manual selector on the module.
`timescale 1ns/1ps
module pio_channel_register_decode
#(
    parameter int BLOCK_SIZE   = pio_pkg::BLOCK_DEF,
    parameter bit PRINTER_MODE = 1'b0
)
(
    input  wire logic                       clk_in,
    input  wire logic                       reset_in,
    input  wire pio_pkg::io_req_t           io_req_in,
    output pio_pkg::io_rsp_t                io_rsp_out,
    input  wire logic [pio_pkg::ADDR_W-1:0] base_select_in,
    input  wire logic                       rx_valid_in,
    input  wire logic [pio_pkg::DATA_W-1:0] rx_data_in,
    input  wire logic                       tx_done_in,
    output logic                            tx_start_out,
    output logic [pio_pkg::DATA_W-1:0]      tx_data_out,
    output logic [pio_pkg::DATA_W-1:0]      line_speed_out,
    output logic [pio_pkg::DATA_W-1:0]      in_command_out,
    output logic [pio_pkg::DATA_W-1:0]      out_command_out
);
    import pio_pkg::*;

    localparam logic [ADDR_W-1:0] BLOCK_LEN = ADDR_W'(BLOCK_SIZE);

    localparam top_state_t RESET_ST = '{
        base_meta: BASE_RESET,
        base_sync: BASE_RESET,
        speed:     SPEED_RESET,
        rsp:       '{done: 1'b0, rdata: READ_ZERO}
    };

    function automatic logic in_block(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] off;
        off = addr - base;
        return off < BLOCK_LEN;
    endfunction

    function automatic logic [3:0] reg_number(input logic [ADDR_W-1:0] addr,
                                              input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] off;
        off = addr - base;
        return off[3:0];
    endfunction

    top_state_t st;
    top_state_t next_st;

    logic                hit;
    logic                is_write;
    logic [3:0]          reg_no;
    logic                in_cmd_wr;
    logic                out_cmd_wr;
    logic                out_data_wr;
    logic                in_data_rd;
    logic                speed_wr;
    logic [DATA_W-1:0]   read_mux;
    logic [DATA_W-1:0]   in_command;
    logic [DATA_W-1:0]   in_condition;
    logic [DATA_W-1:0]   in_data;
    logic [DATA_W-1:0]   out_command;
    logic [DATA_W-1:0]   out_condition;
    logic [DATA_W-1:0]   out_data;
    logic                in_start_unused;
    logic                rx_event;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    always_comb
    begin
        hit      = io_req_in.strobe && in_block(io_req_in.addr, st.base_sync);
        reg_no   = reg_number(io_req_in.addr, st.base_sync);
        is_write = io_req_in.addr[0];
        in_cmd_wr   = 1'b0;
        out_cmd_wr  = 1'b0;
        out_data_wr = 1'b0;
        in_data_rd  = 1'b0;
        speed_wr    = 1'b0;
        read_mux    = READ_ZERO;
        if (PRINTER_MODE)
        begin
            // Only the output channel is decoded here
            out_cmd_wr  = hit && is_write && reg_no == REG_LP_CMD;
            out_data_wr = hit && is_write && reg_no == REG_LP_DATA;
            if (reg_no == REG_LP_COND)
                read_mux = out_condition;
            else if (reg_no == REG_LP_LOOP)
                read_mux = out_data;
        end
        else
        begin
            in_cmd_wr   = hit && is_write && reg_no == REG_IN_CMD;
            out_cmd_wr  = hit && is_write && reg_no == REG_OUT_CMD;
            out_data_wr = hit && is_write && reg_no == REG_OUT_DATA;
            speed_wr    = hit && is_write && reg_no == REG_SPEED;
            in_data_rd  = hit && !is_write && reg_no == REG_IN_DATA;
            if (reg_no == REG_IN_DATA)
                read_mux = in_data;
            else if (reg_no == REG_IN_COND)
                read_mux = in_condition;
            else if (reg_no == REG_OUT_COND)
                read_mux = out_condition;
        end
    end

    // Writes never return a word, so an odd address reads as zero
    always_comb
    begin
        next_st = st;
        next_st.base_meta = base_select_in;
        next_st.base_sync = st.base_meta;
        if (speed_wr)
            next_st.speed = io_req_in.wdata;
        next_st.rsp.done  = hit;
        next_st.rsp.rdata = (hit && !is_write) ? read_mux : READ_ZERO;
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            st <= RESET_ST;
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////
    // Channels; printer form keeps the input side idle
    assign rx_event = rx_valid_in && !PRINTER_MODE;

    pio_channel #(.IS_INPUT(1'b1)) u_in_chan
    (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .cmd_write_in  (in_cmd_wr),
        .data_write_in (1'b0),
        .data_read_in  (in_data_rd),
        .wdata_in      (io_req_in.wdata),
        .line_event_in (rx_event),
        .line_data_in  (rx_data_in),
        .command_out   (in_command),
        .condition_out (in_condition),
        .data_out      (in_data),
        .start_out     (in_start_unused)
    );

    pio_channel #(.IS_INPUT(1'b0)) u_out_chan
    (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .cmd_write_in  (out_cmd_wr),
        .data_write_in (out_data_wr),
        .data_read_in  (1'b0),
        .wdata_in      (io_req_in.wdata),
        .line_event_in (tx_done_in),
        .line_data_in  (READ_ZERO),
        .command_out   (out_command),
        .condition_out (out_condition),
        .data_out      (out_data),
        .start_out     (tx_start_out)
    );

    assign io_rsp_out      = st.rsp;
    assign tx_data_out     = out_data;
    assign line_speed_out  = st.speed;
    assign in_command_out  = in_command;
    assign out_command_out = out_command;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_write_to(logic [3:0] r);
        io_req_in.strobe && in_block(io_req_in.addr, st.base_sync) && io_req_in.addr[0]
            && reg_number(io_req_in.addr, st.base_sync) == r;
    endsequence

    sequence s_read_of(logic [3:0] r);
        io_req_in.strobe && in_block(io_req_in.addr, st.base_sync) && !io_req_in.addr[0]
            && reg_number(io_req_in.addr, st.base_sync) == r;
    endsequence

    a_block_size_range: assert property
        (BLOCK_SIZE >= BLOCK_MIN && BLOCK_SIZE <= BLOCK_MAX)
        else $error("block size outside 4 to 16");

    a_outside_no_answer: assert property
        (io_req_in.strobe && !in_block(io_req_in.addr, st.base_sync) |=> !io_rsp_out.done)
        else $error("answer to an address outside the block");

    a_inside_answer: assert property
        (io_req_in.strobe && in_block(io_req_in.addr, st.base_sync) |=> io_rsp_out.done)
        else $error("no answer to an address inside the block");

    a_write_reads_zero: assert property
        (io_req_in.strobe && io_req_in.addr[0] |=> io_rsp_out.rdata == READ_ZERO)
        else $error("odd address returned data");

    a_base_follows_sel: assert property
        ($stable(base_select_in) [*3] |-> st.base_sync == base_select_in)
        else $error("base number does not follow the selector");

    a_unmapped_quiet: assert property
        (s_read_of(4'h4) or s_write_to(4'h4)
            |=> io_rsp_out.rdata == READ_ZERO && $stable(in_command) && $stable(out_command)
                && $stable(line_speed_out))
        else $error("unassigned number had an effect");

    a_cmd_echo: assert property
        (out_cmd_wr |=> out_condition[CMD_ECHO_W-1:0] == $past(io_req_in.wdata[CMD_ECHO_W-1:0]))
        else $error("condition does not echo the command");

    a_chan_independent: assert property
        (in_cmd_wr |=> $stable(out_command) && in_command == $past(io_req_in.wdata))
        else $error("input command disturbed the output channel");

    generate
        if (PRINTER_MODE)
        begin : g_lp_checks
            a_loopback_read: assert property
                (s_read_of(REG_LP_LOOP) |=> io_rsp_out.rdata == $past(out_data))
                else $error("loop-back read differs from output data");
            a_lp_data_write: assert property
                (s_write_to(REG_LP_DATA) |=> tx_data_out == $past(io_req_in.wdata)
                    && !out_condition[COND_READY_BIT])
                else $error("printer data write not taken");
        end
        else
        begin : g_term_checks
            a_in_cond_read: assert property
                (s_read_of(REG_IN_COND) |=> io_rsp_out.rdata == $past(in_condition))
                else $error("input condition read wrong");
            a_rx_read_clears: assert property
                (s_read_of(REG_IN_DATA) ##0 !rx_valid_in
                    |=> !in_condition[COND_READY_BIT] ##0 io_rsp_out.rdata == $past(in_data))
                else $error("input data read did not empty the channel");
            a_tx_start: assert property
                (s_write_to(REG_OUT_DATA) ##0 out_command[CMD_ACTIVE_BIT]
                    |=> tx_start_out && tx_data_out == $past(io_req_in.wdata))
                else $error("transmit data write did not start the line");
            a_speed_write: assert property
                (s_write_to(REG_SPEED) |=> line_speed_out == $past(io_req_in.wdata))
                else $error("speed register not written");
            a_both_ways: assert property
                (rx_valid_in && in_command[CMD_ACTIVE_BIT] && tx_done_in && !out_data_wr
                    |=> in_condition[COND_READY_BIT] && out_condition[COND_READY_BIT])
                else $error("channels did not run at the same time");
        end
    endgenerate
endmodule

// File: hdl/pio_pkg.sv
// Shared constants and carrier types for the programmed_io register decode
package pio_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;

    // Block size limits and default
    localparam int BLOCK_MIN  = 4;
    localparam int BLOCK_MAX  = 16;
    localparam int BLOCK_DEF  = 8;

    // Terminal map
    localparam logic [3:0] REG_IN_DATA  = 4'h0;
    localparam logic [3:0] REG_SPEED    = 4'h1;
    localparam logic [3:0] REG_IN_COND  = 4'h2;
    localparam logic [3:0] REG_IN_CMD   = 4'h3;
    localparam logic [3:0] REG_OUT_DATA = 4'h5;
    localparam logic [3:0] REG_OUT_COND = 4'h6;
    localparam logic [3:0] REG_OUT_CMD  = 4'h7;

    // Printer map
    localparam logic [3:0] REG_LP_LOOP  = 4'h0;
    localparam logic [3:0] REG_LP_DATA  = 4'h1;
    localparam logic [3:0] REG_LP_COND  = 4'h2;
    localparam logic [3:0] REG_LP_CMD   = 4'h3;

    // Command and condition fields
    localparam int CMD_ECHO_W       = 3;
    localparam int CMD_ACTIVE_BIT   = 2;
    localparam int COND_READY_BIT   = 3;
    localparam int COND_ERROR_BIT   = 4;
    localparam int COND_OVERRUN_BIT = 5;

    // Reset values
    localparam logic [15:0] CMD_RESET   = 16'h0000;
    localparam logic [15:0] DATA_RESET  = 16'h0000;
    localparam logic [15:0] SPEED_RESET = 16'h0000;
    localparam logic [15:0] BASE_RESET  = 16'h0000;
    localparam logic [15:0] READ_ZERO   = 16'h0000;

    typedef struct packed {
        logic              strobe;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic              done;
        logic [DATA_W-1:0] rdata;
    } io_rsp_t;

    typedef struct packed {
        logic [DATA_W-1:0] command;
        logic [DATA_W-1:0] data;
        logic              ready;
        logic              overrun;
        logic              start;
    } chan_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] base_meta;
        logic [ADDR_W-1:0] base_sync;
        logic [DATA_W-1:0] speed;
        io_rsp_t           rsp;
    } top_state_t;
endpackage

// File: hdl/pio_channel.sv
// One transfer channel: command, condition and data registers
`timescale 1ns/1ps
module pio_channel
#(
    parameter bit IS_INPUT = 1'b1
)
(
    input  wire logic                   clk_in,
    input  wire logic                   reset_in,
    input  wire logic                   cmd_write_in,
    input  wire logic                   data_write_in,
    input  wire logic                   data_read_in,
    input  wire logic [pio_pkg::DATA_W-1:0] wdata_in,
    input  wire logic                   line_event_in,
    input  wire logic [pio_pkg::DATA_W-1:0] line_data_in,
    output logic [pio_pkg::DATA_W-1:0]  command_out,
    output logic [pio_pkg::DATA_W-1:0]  condition_out,
    output logic [pio_pkg::DATA_W-1:0]  data_out,
    output logic                        start_out
);
    import pio_pkg::*;

    // Output data register starts empty, input starts with nothing held
    localparam chan_state_t RESET_ST = '{
        command: CMD_RESET,
        data:    DATA_RESET,
        ready:   !IS_INPUT,
        overrun: 1'b0,
        start:   1'b0
    };

    chan_state_t st;
    chan_state_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.start = 1'b0;
        // Command write first so a same-cycle error set wins over the clear
        if (cmd_write_in)
        begin
            next_st.command = wdata_in;
            next_st.overrun = 1'b0;
        end
        if (IS_INPUT)
        begin
            if (data_read_in)
                next_st.ready = 1'b0;
            if (line_event_in && st.command[CMD_ACTIVE_BIT])
            begin
                next_st.data  = line_data_in;
                next_st.ready = 1'b1;
                if (st.ready && !data_read_in)
                    next_st.overrun = 1'b1;
            end
        end
        else
        begin
            if (line_event_in)
                next_st.ready = 1'b1;
            if (data_write_in)
            begin
                next_st.data  = wdata_in;
                next_st.ready = 1'b0;
                next_st.start = st.command[CMD_ACTIVE_BIT];
                if (!st.ready && !line_event_in)
                    next_st.overrun = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            st <= RESET_ST;
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        condition_out = READ_ZERO;
        condition_out[CMD_ECHO_W-1:0]   = st.command[CMD_ECHO_W-1:0];
        condition_out[COND_READY_BIT]   = st.ready;
        condition_out[COND_ERROR_BIT]   = st.overrun;
        condition_out[COND_OVERRUN_BIT] = st.overrun;
    end

    assign command_out = st.command;
    assign data_out    = st.data;
    assign start_out   = st.start;
endmodule

// File: testbench/pio_cpu_model.sv
// CPU side model issuing register exchanges on the request carrier
`timescale 1ns/1ps
module pio_cpu_model
(
    input  wire logic             clk_in,
    input  wire pio_pkg::io_rsp_t rsp_in,
    output pio_pkg::io_req_t      req_out
);
    import pio_pkg::*;

    // Idle cycles before each request, to act as a slow processor
    int slow = 0;

    initial req_out = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // Address is base number plus register number; bit 0 picks direction
    task automatic xfer(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] wdata,
                        output logic got, output logic [DATA_W-1:0] rdata);
        repeat (slow) @(posedge clk_in);
        @(posedge clk_in);
        req_out <= '{strobe: 1'b1, addr: addr, wdata: wdata};
        @(posedge clk_in);
        // Released fields show the inverse so a stale value never passes
        req_out <= '{strobe: 1'b0, addr: ~addr, wdata: ~wdata};
        @(negedge clk_in);
        got   = rsp_in.done;
        rdata = rsp_in.rdata;
    endtask
endmodule

// File: testbench/pio_channel_register_decode_bench.sv
// Self-checking bench for the programmed_io register decode
`timescale 1ns/1ps
module pio_channel_register_decode_bench;
    import pio_pkg::*;

    localparam logic [ADDR_W-1:0] BASE_A  = 16'h00c0;
    localparam logic [ADDR_W-1:0] BASE_B  = 16'h00c8;
    localparam logic [ADDR_W-1:0] BASE_LP = 16'h0118;

    logic              clk_in   = 1'b0;
    logic              reset_in = 1'b1;
    logic [ADDR_W-1:0] base_sel = BASE_A;
    logic [ADDR_W-1:0] base_lp  = BASE_LP;
    logic              rx_valid = 1'b0;
    logic [DATA_W-1:0] rx_data  = 16'h0000;
    logic              tx_done  = 1'b0;
    io_req_t           req;
    io_req_t           req_lp;
    io_rsp_t           rsp;
    io_rsp_t           rsp_lp;
    logic              tx_start;
    logic [DATA_W-1:0] tx_data;
    logic [DATA_W-1:0] lp_data;
    logic [DATA_W-1:0] speed;
    logic [DATA_W-1:0] in_cmd;
    logic [DATA_W-1:0] out_cmd;
    int                err_total = 0;
    int                checks    = 0;
    int                starts    = 0;

    always #4 clk_in = ~clk_in;

    ////////////////////////////////////////////////////////////////////////////////
    pio_channel_register_decode #(.BLOCK_SIZE(8), .PRINTER_MODE(1'b0)) uut
    (
        .clk_in(clk_in), .reset_in(reset_in), .io_req_in(req), .io_rsp_out(rsp),
        .base_select_in(base_sel), .rx_valid_in(rx_valid), .rx_data_in(rx_data),
        .tx_done_in(tx_done), .tx_start_out(tx_start), .tx_data_out(tx_data),
        .line_speed_out(speed), .in_command_out(in_cmd), .out_command_out(out_cmd)
    );

    // Printer form sees the same receive pulses and must ignore them
    pio_channel_register_decode #(.BLOCK_SIZE(4), .PRINTER_MODE(1'b1)) uut_lp
    (
        .clk_in(clk_in), .reset_in(reset_in), .io_req_in(req_lp), .io_rsp_out(rsp_lp),
        .base_select_in(base_lp), .rx_valid_in(rx_valid), .rx_data_in(rx_data),
        .tx_done_in(tx_done), .tx_start_out(), .tx_data_out(lp_data),
        .line_speed_out(), .in_command_out(), .out_command_out()
    );

    pio_cpu_model cpu (.clk_in(clk_in), .rsp_in(rsp), .req_out(req));
    pio_cpu_model cpu_lp (.clk_in(clk_in), .rsp_in(rsp_lp), .req_out(req_lp));

    // Sampled on the falling edge, clear of the launching edge
    always @(negedge clk_in)
        if (tx_start === 1'b1)
            starts <= starts + 1;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                       input string what);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic io(input bit lp, input logic [ADDR_W-1:0] addr,
                      input logic [DATA_W-1:0] wdata, input bit exp_done,
                      input logic [DATA_W-1:0] exp_rd);
        logic              got;
        logic [DATA_W-1:0] rd;
        if (lp)
            cpu_lp.xfer(addr, wdata, got, rd);
        else
            cpu.xfer(addr, wdata, got, rd);
        chk({15'h0000, got}, {15'h0000, exp_done}, $sformatf("done at %h", addr));
        if (exp_done)
            chk(rd, exp_rd, $sformatf("read data at %h", addr));
    endtask

    task automatic line_pulse(input bit rx, input bit tx, input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        rx_valid <= rx;
        tx_done  <= tx;
        rx_data  <= d;
        @(posedge clk_in);
        rx_valid <= 1'b0;
        tx_done  <= 1'b0;
        rx_data  <= ~d;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #400000;
        err_total++;
        complete_run();
    end

    initial
    begin
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        // Selector stable through reset, so two edges suffice
        repeat (3) @(posedge clk_in);

        chk(speed, 16'h0000, "speed reset");
        chk(tx_data, 16'h0000, "tx data reset");
        io(0, BASE_A + 16'h0006, 16'h0000, 1, 16'h0008);
        io(0, BASE_A + 16'h0002, 16'h0000, 1, 16'h0000);
        $display("test reset finished");

        io(0, BASE_A + 16'h0003, 16'h0005, 1, 16'h0000);
        chk(in_cmd, 16'h0005, "input command");
        chk(out_cmd, 16'h0000, "output command apart");
        io(0, BASE_A + 16'h0002, 16'hffff, 1, 16'h0005);
        io(0, BASE_A + 16'h0001, 16'h1234, 1, 16'h0000);
        chk(speed, 16'h1234, "line speed");
        $display("test commands finished");

        line_pulse(1, 0, 16'h0041);
        io(0, BASE_A + 16'h0002, 16'h0000, 1, 16'h000d);
        io(0, BASE_A + 16'h0000, 16'h0000, 1, 16'h0041);
        io(0, BASE_A + 16'h0002, 16'h0000, 1, 16'h0005);
        // Second character before the first is read sets both error bits
        line_pulse(1, 0, 16'h0061);
        line_pulse(1, 0, 16'h0062);
        io(0, BASE_A + 16'h0002, 16'h0000, 1, 16'h003d);
        io(0, BASE_A + 16'h0003, 16'h0005, 1, 16'h0000);
        io(0, BASE_A + 16'h0000, 16'h0000, 1, 16'h0062);
        $display("test receive finished");

        io(0, BASE_A + 16'h0007, 16'h0004, 1, 16'h0000);
        chk(out_cmd, 16'h0004, "output command");
        chk(in_cmd, 16'h0005, "input command apart");
        io(0, BASE_A + 16'h0005, 16'h0055, 1, 16'h0000);
        chk(tx_data, 16'h0055, "transmit data");
        io(0, BASE_A + 16'h0006, 16'h0000, 1, 16'h0004);
        chk(starts[15:0], 16'h0001, "transmit starts");
        // Receive and transmit end in the same cycle, both channels at once
        line_pulse(1, 1, 16'h0042);
        io(0, BASE_A + 16'h0000, 16'h0000, 1, 16'h0042);
        io(0, BASE_A + 16'h0006, 16'h0000, 1, 16'h000c);
        $display("test transmit finished");

        io(0, BASE_A + 16'h0004, 16'h0000, 1, 16'h0000);
        chk(speed, 16'h1234, "speed after unassigned");
        io(0, BASE_A + 16'h0008, 16'h0000, 0, 16'h0000);
        io(0, BASE_A - 16'h0001, 16'hbeef, 0, 16'h0000);
        chk(speed, 16'h1234, "speed after outside");
        chk(starts[15:0], 16'h0001, "no stray starts");
        cpu.slow = 3;
        io(0, BASE_A + 16'h0006, 16'h0000, 1, 16'h000c);
        cpu.slow = 0;
        $display("test block edges finished");

        @(posedge clk_in);
        base_sel <= BASE_B;
        repeat (3) @(posedge clk_in);
        io(0, BASE_B + 16'h0001, 16'h0777, 1, 16'h0000);
        io(0, BASE_A + 16'h0001, 16'h0999, 0, 16'h0000);
        chk(speed, 16'h0777, "speed after new base");
        $display("test base select finished");

        io(1, BASE_LP + 16'h0003, 16'h0004, 1, 16'h0000);
        io(1, BASE_LP + 16'h0001, 16'h0041, 1, 16'h0000);
        chk(lp_data, 16'h0041, "printer data");
        io(1, BASE_LP + 16'h0000, 16'h0000, 1, 16'h0041);
        io(1, BASE_LP + 16'h0002, 16'h0000, 1, 16'h0004);
        io(1, BASE_LP + 16'h0004, 16'h0000, 0, 16'h0000);
        $display("test printer finished");

        complete_run();
    end
endmodule
